/* src/bse_pkg.sv */
/*
  Constants and types for the branch and system-control execute block:
  opcode patterns, minimum cycle counts, reset values and port structs.
  Assumes 16-bit instruction words, 32-bit data and sixteen registers.
*/
// Functional notes
// - Branch-if-false: T clear loads PC plus 2*disp in 3 cycles, else 1.
// - Branch-if-true: T set loads PC plus 2*disp in 3 cycles, else 1.
// - Branch-always: delayed branch to PC plus 2*disp12 in 2 cycles.
// - Branch-to-subroutine: PC saved in return register, delayed branch.
// - Jump-indirect: delayed branch to general register value, 2 cycles.
// - Call-indirect: PC saved in return register, delayed jump to Rm.
// - Return: delayed branch to the return register, 2 cycles.
// - Clear-accumulator zeroes both halves in 1 cycle, T unchanged.
// - Control loads from Rm (1 cycle) or memory post-increment (3).
// - System loads from Rm or memory post-increment, 1 cycle each.
// - Control stores to Rn (1 cycle) or pre-decrement memory (2).
// - System stores to Rn or pre-decrement memory, 1 cycle each.
// - Return-from-exception pops PC and status as delayed branch, 4 cycles.
// - Sleep takes 3 execution states before entering sleep.
// - Trap pushes PC and status, loads PC from vector base plus 4*imm.
// - Cycle counts are minimums; more cycles may be taken.
// - Memory contention and load-use dependence insert extra cycles.
package bse_pkg;
  localparam logic [7:0]  OP_BF     = 8'h8b;
  localparam logic [7:0]  OP_BT     = 8'h89;
  localparam logic [7:0]  OP_TRAP   = 8'hc3;
  localparam logic [3:0]  OP_BRA    = 4'ha;
  localparam logic [3:0]  OP_BSR    = 4'hb;
  localparam logic [3:0]  GRP_0     = 4'h0;
  localparam logic [3:0]  GRP_4     = 4'h4;
  localparam logic [7:0]  LO_JSR    = 8'h0b;
  localparam logic [7:0]  LO_JMP    = 8'h2b;
  localparam logic [15:0] W_RTS     = 16'h000b;
  localparam logic [15:0] W_CLEAR_TEST_FLAG    = 16'h0008;
  localparam logic [15:0] W_SET_TEST_FLAG    = 16'h0018;
  localparam logic [15:0] W_CLEAR_ACCUMULATOR  = 16'h0028;
  localparam logic [15:0] W_SLEEP   = 16'h001b;
  localparam logic [15:0] W_RTE     = 16'h002b;
  localparam logic [3:0]  NB_LDC    = 4'he;
  localparam logic [3:0]  NB_LDCM   = 4'h7;
  localparam logic [3:0]  NB_LDS    = 4'ha;
  localparam logic [3:0]  NB_LDSM   = 4'h6;
  localparam logic [3:0]  NB_STC    = 4'h2;
  localparam logic [3:0]  NB_STCM   = 4'h3;
  localparam logic [3:0]  NB_STS    = 4'ha;
  localparam logic [3:0]  NB_STSM   = 4'h2;
  localparam logic [1:0]  SEL_0     = 2'h0;
  localparam logic [1:0]  SEL_1     = 2'h1;
  localparam logic [1:0]  SEL_BAD   = 2'h3;
  localparam logic [2:0]  CYC_ONE   = 3'h1;
  localparam logic [2:0]  CYC_DLY   = 3'h2;
  localparam logic [2:0]  CYC_TAKEN = 3'h3;
  localparam logic [2:0]  CYC_LDCM  = 3'h3;
  localparam logic [2:0]  CYC_STCM  = 3'h2;
  localparam logic [2:0]  CYC_RTE   = 3'h4;
  localparam logic [2:0]  CYC_SLEEP = 3'h3;
  localparam logic [2:0]  CYC_TRAP  = 3'h0;
  localparam logic [31:0] ADDR_STEP = 32'h4;
  localparam logic [31:0] SP_FRAME  = 32'h8;
  localparam logic [3:0]  SP_IDX    = 4'hf;
  localparam logic [31:0] RST_WORD  = 32'h0;
  localparam int          T_BIT     = 0;
  // The trap count wraps the 3-bit counter: 8 cycles reload as 0 - 1 = 7.
  typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_ARM, ST_SLEEP} bse_state_t;
  typedef enum logic [2:0] {MK_LDC, MK_LDS, MK_WR, MK_RTE, MK_TRAP} bse_kind_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    logic [31:0] pc;
    logic [31:0] regVal;
    logic [31:0] stackPtr;
  } bse_insn_t;
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bse_mem_t;
  typedef struct packed {
    logic        we;
    logic [3:0]  idx;
    logic [31:0] data;
  } bse_regwr_t;
  typedef struct packed {
    logic        load;
    logic        delayed;
    logic [31:0] target;
  } bse_pcld_t;
  typedef struct packed {
    logic [31:0] sr;
    logic [31:0] global_base_register;
    logic [31:0] vector_base_register;
    logic [31:0] pr;
    logic [31:0] accumulator_high;
    logic [31:0] accumulator_low;
  } bse_sysregs_t;
endpackage

/* src/bse_branch_sysctl_exec.sv */
/*
  Execute stage for branch and system-control instructions: decodes the
  issued word, sequences data-memory accesses and holds the control and
  system registers. Assumes the register file bypasses regWr onto regVal
  and the fetch unit honours pcLd, running one slot when it is delayed.
*/
`timescale 1ns/1ns
module bse_branch_sysctl_exec (
  // Clock and reset.
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Instruction issue.
  input  wire bse_pkg::bse_insn_t     insn,
  output logic                        insReady,
  // Data memory bus.
  output bse_pkg::bse_mem_t           mem,
  input  wire logic [31:0]            memRdata,
  input  wire logic                   memAck,
  // Register write-back and PC load.
  output bse_pkg::bse_regwr_t         regWr,
  output bse_pkg::bse_pcld_t          pcLd,
  // Core state.
  output bse_pkg::bse_sysregs_t       sysRegs,
  output logic                        tFlag,
  output logic                        sleepMode,
  input  wire logic                   wakeUp
);
  import bse_pkg::*;

  bse_state_t  state;
  bse_state_t  next_state;
  bse_kind_t   memKind;
  bse_kind_t   next_kind;
  logic [2:0]  minCnt;
  logic [2:0]  next_minCnt;
  logic [2:0]  cycNeed;
  logic [1:0]  memStep;
  logic [1:0]  memSel;
  logic        memWrite;
  logic [31:0] memAddr;
  logic [31:0] memWdata;
  logic [31:0] holdWord;
  logic [31:0] vecAddr;
  logic [31:0] sr;
  logic [31:0] global_base_register;
  logic [31:0] vector_base_register;
  logic [31:0] pr;
  logic [31:0] accumulator_high;
  logic [31:0] accumulator_low;

  // Decode of the issued word.
  logic [15:0] w;
  logic [1:0]  sel;
  logic        selOk;
  logic        is0;
  logic        is4;
  assign w     = insn.word;
  assign sel   = w[5:4];
  assign selOk = (w[7:6] == 2'h0) && (sel != SEL_BAD);
  assign is0   = (w[15:12] == GRP_0);
  assign is4   = (w[15:12] == GRP_4);

  logic isBf, isBt, isBra, isBsr, isJmp, isJsr, isRts, isTrap;
  logic isClrt, isSett, isClrmac, isSleep, isRte;
  logic isLdc, isLdcM, isLds, isLdsM, isStc, isStcM, isSts, isStsM;
  assign isBf     = (w[15:8] == OP_BF);
  assign isBt     = (w[15:8] == OP_BT);
  assign isBra    = (w[15:12] == OP_BRA);
  assign isBsr    = (w[15:12] == OP_BSR);
  assign isTrap   = (w[15:8] == OP_TRAP);
  assign isJmp    = is4 && (w[7:0] == LO_JMP);
  assign isJsr    = is4 && (w[7:0] == LO_JSR);
  assign isRts    = (w == W_RTS);
  assign isClrt   = (w == W_CLEAR_TEST_FLAG);
  assign isSett   = (w == W_SET_TEST_FLAG);
  assign isClrmac = (w == W_CLEAR_ACCUMULATOR);
  assign isSleep  = (w == W_SLEEP);
  assign isRte    = (w == W_RTE);
  assign isLdc    = is4 && selOk && (w[3:0] == NB_LDC);
  assign isLdcM   = is4 && selOk && (w[3:0] == NB_LDCM);
  assign isLds    = is4 && selOk && (w[3:0] == NB_LDS);
  assign isLdsM   = is4 && selOk && (w[3:0] == NB_LDSM);
  assign isStc    = is0 && selOk && (w[3:0] == NB_STC);
  assign isStcM   = is4 && selOk && (w[3:0] == NB_STCM);
  assign isSts    = is0 && selOk && (w[3:0] == NB_STS);
  assign isStsM   = is4 && selOk && (w[3:0] == NB_STSM);

  logic        tNow, bfTaken, btTaken, delayedBr, needMem, isSysOp;
  logic [31:0] brTarget, jumpTarget, ctlAcc, sysAcc;
  assign tNow      = sr[T_BIT];
  assign bfTaken   = isBf && !tNow;
  assign btTaken   = isBt && tNow;
  assign delayedBr = isBra || isBsr || isJmp || isJsr || isRts;
  assign needMem   = isLdcM || isLdsM || isStcM || isStsM || isRte || isTrap;
  assign isSysOp   = isBf || isBt || isRts || isTrap || isRte || isClrt
                  || isSett || isClrmac || isLdc || isLdcM || isLds
                  || isLdsM || isStc || isStcM || isSts || isStsM;
  assign brTarget  = insn.pc + ((isBra || isBsr)
                   ? {{19{w[11]}}, w[11:0], 1'b0}
                   : {{23{w[7]}}, w[7:0], 1'b0});
  assign jumpTarget = (isJmp || isJsr) ? insn.regVal
                    : isRts ? pr : brTarget;
  assign ctlAcc = (sel == SEL_0) ? sr : (sel == SEL_1) ? global_base_register : vector_base_register;
  assign sysAcc = (sel == SEL_0) ? accumulator_high : (sel == SEL_1) ? accumulator_low : pr;

  // Minimum execution cycles of the issued word.
  assign cycNeed = (bfTaken || btTaken) ? CYC_TAKEN
                 : delayedBr ? CYC_DLY
                 : isLdcM ? CYC_LDCM
                 : isStcM ? CYC_STCM
                 : isRte ? CYC_RTE
                 : isSleep ? CYC_SLEEP
                 : isTrap ? CYC_TRAP : CYC_ONE;
  assign next_kind = (isLdcM) ? MK_LDC : isLdsM ? MK_LDS
                   : isRte ? MK_RTE : isTrap ? MK_TRAP : MK_WR;

  // Issue handshake and memory sequencing status.
  logic memDone, lastStep, finishing, overlapOk, pendingLoad, hazard;
  logic accept, rteDone, trapDone;
  assign memDone     = (state == ST_MEM) && memAck;
  assign lastStep    = (memKind == MK_RTE) ? (memStep == 2'h1)
                     : (memKind == MK_TRAP) ? (memStep == 2'h2) : 1'b1;
  assign finishing   = memDone && lastStep;
  assign overlapOk   = finishing && (memKind != MK_RTE)
                     && (memKind != MK_TRAP);
  assign pendingLoad = (state == ST_MEM)
                     && (memKind == MK_LDC || memKind == MK_LDS);
  assign hazard      = pendingLoad && isSysOp;
  assign insReady    = ((state == ST_IDLE) || overlapOk)
                     && (minCnt == 3'h0) && !hazard;
  assign accept      = insn.valid && insReady;
  assign rteDone     = memDone && (memKind == MK_RTE) && (memStep == 2'h1);
  assign trapDone    = memDone && (memKind == MK_TRAP) && (memStep == 2'h2);
  assign next_minCnt = accept ? cycNeed - 3'h1
                     : (minCnt != 3'h0) ? minCnt - 3'h1 : minCnt;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_MEM: if (finishing) next_state = ST_IDLE;
      ST_ARM: if (minCnt == 3'h1) next_state = ST_SLEEP;
      ST_SLEEP: if (wakeUp) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
    if (accept && needMem) next_state = ST_MEM;
    else if (accept && isSleep) next_state = ST_ARM;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state  <= ST_IDLE;
      minCnt <= 3'h0;
    end else begin
      state  <= next_state;
      minCnt <= next_minCnt;
    end
  end

  // Data access set-up at issue, then one step per acknowledge.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      memKind  <= MK_LDC;
      memSel   <= SEL_0;
      memStep  <= 2'h0;
      memWrite <= 1'b0;
      memAddr  <= RST_WORD;
      memWdata <= RST_WORD;
      holdWord <= RST_WORD;
      vecAddr  <= RST_WORD;
    end else if (accept) begin
      memKind  <= next_kind;
      memSel   <= sel;
      memStep  <= 2'h0;
      holdWord <= insn.pc;
      vecAddr  <= vector_base_register + {22'h0, w[7:0], 2'h0};
      memWrite <= isStcM || isStsM || isTrap;
      memAddr  <= (isLdcM || isLdsM) ? insn.regVal
                : isRte ? insn.stackPtr
                : isTrap ? insn.stackPtr - ADDR_STEP
                : insn.regVal - ADDR_STEP;
      memWdata <= isStcM ? ctlAcc : isStsM ? sysAcc : sr;
    end else if (memDone) begin
      memStep <= memStep + 2'h1;
      if (memKind == MK_RTE) begin
        holdWord <= memRdata;
        memAddr  <= memAddr + ADDR_STEP;
      end else if (memKind == MK_TRAP && memStep == 2'h0) begin
        memAddr  <= memAddr - ADDR_STEP;
        memWdata <= holdWord;
      end else if (memKind == MK_TRAP) begin
        memAddr  <= vecAddr;
        memWrite <= 1'b0;
      end
    end
  end

  // Control and system registers; issue wins over a finishing load.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sr   <= RST_WORD;
      global_base_register  <= RST_WORD;
      vector_base_register  <= RST_WORD;
      pr   <= RST_WORD;
      accumulator_high <= RST_WORD;
      accumulator_low <= RST_WORD;
    end else begin
      if (memDone && memKind == MK_LDC) begin
        case (memSel)
          SEL_0: sr <= memRdata;
          SEL_1: global_base_register <= memRdata;
          default: vector_base_register <= memRdata;
        endcase
      end
      if (memDone && memKind == MK_LDS) begin
        case (memSel)
          SEL_0: accumulator_high <= memRdata;
          SEL_1: accumulator_low <= memRdata;
          default: pr <= memRdata;
        endcase
      end
      if (rteDone) sr <= memRdata;
      if (accept && (isClrt || isSett)) sr[T_BIT] <= isSett;
      if (accept && isClrmac) begin
        accumulator_high <= RST_WORD;
        accumulator_low <= RST_WORD;
      end
      if (accept && isLdc) begin
        case (sel)
          SEL_0: sr <= insn.regVal;
          SEL_1: global_base_register <= insn.regVal;
          default: vector_base_register <= insn.regVal;
        endcase
      end
      if (accept && isLds) begin
        case (sel)
          SEL_0: accumulator_high <= insn.regVal;
          SEL_1: accumulator_low <= insn.regVal;
          default: pr <= insn.regVal;
        endcase
      end
      if (accept && (isBsr || isJsr)) pr <= insn.pc;
    end
  end

  // General register write-back and PC load pulses.
  logic        next_regWe;
  logic [3:0]  next_regIdx;
  logic [31:0] next_regData;
  assign next_regWe   = isLdcM || isLdsM || isStcM || isStsM || isStc
                     || isSts || isRte || isTrap;
  assign next_regIdx  = (isRte || isTrap) ? SP_IDX : w[11:8];
  assign next_regData = (isLdcM || isLdsM) ? insn.regVal + ADDR_STEP
                      : (isStcM || isStsM) ? insn.regVal - ADDR_STEP
                      : isStc ? ctlAcc
                      : isSts ? sysAcc
                      : isRte ? insn.stackPtr + SP_FRAME
                      : insn.stackPtr - SP_FRAME;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      regWr <= '0;
      pcLd  <= '0;
    end else begin
      regWr <= '{accept && next_regWe, next_regIdx, next_regData};
      if (accept && (bfTaken || btTaken || delayedBr))
        pcLd <= '{1'b1, delayedBr, jumpTarget};
      else if (rteDone)
        pcLd <= '{1'b1, 1'b1, holdWord};
      else if (trapDone)
        pcLd <= '{1'b1, 1'b0, memRdata};
      else
        pcLd <= '{1'b0, pcLd.delayed, pcLd.target};
    end
  end

  assign mem       = '{state == ST_MEM, memWrite, memAddr, memWdata};
  assign sysRegs   = '{sr, global_base_register, vector_base_register, pr, accumulator_high, accumulator_low};
  assign tFlag     = sr[T_BIT];
  assign sleepMode = (state == ST_SLEEP);

  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_busy2;
    !insReady ##1 !insReady;
  endsequence
  sequence s_arm3;
    !sleepMode ##1 !sleepMode ##1 sleepMode;
  endsequence

  property p_bf;
    accept && isBf && !tNow |=> pcLd.load && !pcLd.delayed
      && pcLd.target == $past(brTarget) ##0 s_busy2;
  endproperty
  a_bf: assert property (p_bf) else $error("bf not taken right");
  property p_bf_skip;
    accept && isBf && tNow |=> !pcLd.load && insReady == !hazard;
  endproperty
  a_bf_skip: assert property (p_bf_skip) else $error("bf skip");
  property p_bt;
    accept && isBt |=> pcLd.load == $past(tNow) ##0 s_busy2 or !$past(tNow);
  endproperty
  a_bt: assert property (p_bt) else $error("bt wrong");
  property p_bra;
    accept && isBra |=> pcLd.load && pcLd.target == $past(brTarget)
      && minCnt == 3'h1 ##1 minCnt == 3'h0;
  endproperty
  a_bra: assert property (p_bra) else $error("bra wrong");
  property p_bsr;
    accept && isBsr |=> sysRegs.pr == $past(insn.pc) && pcLd.delayed;
  endproperty
  a_bsr: assert property (p_bsr) else $error("bsr wrong");
  property p_jmp;
    accept && isJmp |=> pcLd.target == $past(insn.regVal) && pcLd.load;
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump wrong");
  property p_jsr;
    accept && isJsr |=> sysRegs.pr == $past(insn.pc)
      && pcLd.target == $past(insn.regVal);
  endproperty
  a_jsr: assert property (p_jsr) else $error("call wrong");
  property p_rts;
    accept && isRts |=> pcLd.load && pcLd.target == $past(pr);
  endproperty
  a_rts: assert property (p_rts) else $error("return wrong");
  property p_clear_accumulator;
    accept && isClrmac |=> accumulator_high == 32'h0 && accumulator_low == 32'h0
      && tFlag == $past(tFlag);
  endproperty
  a_clear_accumulator: assert property (p_clear_accumulator) else $error("clear_accumulator");
  property p_ldc;
    accept && isLdcM |=> mem.req && !mem.write
      && mem.addr == $past(insn.regVal) ##0 s_busy2;
  endproperty
  a_ldc: assert property (p_ldc) else $error("ldc mem wrong");
  property p_lds;
    accept && isLds && sel == SEL_0 |=> accumulator_high == $past(insn.regVal);
  endproperty
  a_lds: assert property (p_lds) else $error("lds wrong");
  property p_stc;
    accept && isStcM |=> mem.write && mem.addr == $past(insn.regVal) - 32'h4;
  endproperty
  a_stc: assert property (p_stc) else $error("stc mem wrong");
  property p_sts;
    accept && isSts |=> regWr.we && regWr.data == $past(sysAcc);
  endproperty
  a_sts: assert property (p_sts) else $error("sts wrong");
  property p_rte;
    accept && isRte |=> !insReady [*3];
  endproperty
  a_rte: assert property (p_rte) else $error("rte too short");
  property p_sleep;
    accept && isSleep |=> s_arm3;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep timing");
  property p_trap;
    accept && isTrap |=> mem.write
      && mem.addr == $past(insn.stackPtr) - 32'h4 ##0 !insReady [*7];
  endproperty
  a_trap: assert property (p_trap) else $error("trap wrong");
  property p_min;
    accept && isStcM |=> !insReady;
  endproperty
  a_min: assert property (p_min) else $error("stc too short");
  property p_stall;
    (state == ST_MEM) && !memAck |-> !insReady;
  endproperty
  a_stall: assert property (p_stall) else $error("no stall");
  property p_tflag;
    accept && (isClrt || isSett) |=> tFlag == $past(isSett);
  endproperty
  a_tflag: assert property (p_tflag) else $error("t flag");
  property p_slot;
    accept && delayedBr |=> pcLd.load && pcLd.delayed;
  endproperty
  a_slot: assert property (p_slot) else $error("not delayed");

endmodule // bse_branch_sysctl_exec

/* dv/bse_mem_model.sv */
/*
  Data memory partner for the execute block: answers each access after
  ackDelay wait cycles and records the last write.
  Assumes one access is pending at a time, as the block issues them.
*/
`timescale 1ns/1ns
module bse_mem_model (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Memory bus.
  input  wire bse_pkg::bse_mem_t mem,
  output logic [31:0]            memRdata,
  output logic                   memAck,
  // Wait control and write capture.
  input  wire logic [1:0]        ackDelay,
  output logic [31:0]            lastAddr,
  output logic [31:0]            lastData
);
  import bse_pkg::*;
  logic [1:0]  waitCnt;
  logic [31:0] prevRd;
  // Read data is a fixed function of the address; idle data is inverted.
  assign memAck   = mem.req && (waitCnt == ackDelay);
  assign memRdata = memAck ? (mem.addr ^ 32'ha5a50000) : ~prevRd;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      waitCnt <= 2'h0;
      prevRd  <= 32'h0;
    end else begin
      waitCnt <= (mem.req && !memAck) ? waitCnt + 2'h1 : 2'h0;
      if (memAck) begin
        prevRd <= memRdata;
      end
      if (memAck && mem.write) begin
        lastAddr <= mem.addr;
        lastData <= mem.wdata;
      end
    end
  end
endmodule // bse_mem_model

/* dv/tb_branch_sysctl_exec.sv */
/*
  Testbench for the branch and system-control execute block: issues
  words and checks flow, register and memory effects.
  Assumes the fetch PC is 0x1000 for every word and memory model partner.
*/
`timescale 1ns/1ns
module tb_branch_sysctl_exec;
  import bse_pkg::*;
  logic         clk_sys = 1'b0;
  logic         rst_n = 1'b0;
  logic         wakeUp = 1'b0;
  logic [1:0]   ackDelay = 2'h0;
  bse_insn_t    insn = '0;
  logic         insReady, memAck, tFlag, sleepMode;
  logic [31:0]  memRdata, lastAddr, lastData, wrData;
  logic [3:0]   wrIdx;
  bse_mem_t     mem;
  bse_regwr_t   regWr;
  bse_pcld_t    pcLd;
  bse_sysregs_t sysRegs;
  int           numErrors = 0;
  int           cmpCount = 0;
  int           loadCnt = 0;
  int           gapSeen;
  always #20 clk_sys = ~clk_sys;
  bse_branch_sysctl_exec bse_branch_sysctl_exec_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .insn(insn), .insReady(insReady), .mem(mem),
    .memRdata(memRdata), .memAck(memAck), .regWr(regWr), .pcLd(pcLd),
    .sysRegs(sysRegs), .tFlag(tFlag), .sleepMode(sleepMode),
    .wakeUp(wakeUp));
  bse_mem_model bse_mem_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .mem(mem), .memRdata(memRdata), .memAck(memAck), .ackDelay(ackDelay),
    .lastAddr(lastAddr), .lastData(lastData));
  // Counts PC loads at each edge.
  always @(posedge clk_sys) begin
    if (pcLd.load === 1'b1) begin
      loadCnt++;
    end
  end
  // Keeps the last write-back as soon as its pulse appears, so that a
  // one-cycle word can be checked in the cycle after it issues.
  always @(regWr) begin
    if (regWr.we === 1'b1) begin
      wrIdx = regWr.idx;
      wrData = regWr.data;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      numErrors++;
    end
  endtask
  task completeRun();
    if (numErrors == 0 && cmpCount > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Offers one word, then counts cycles until the next word may issue.
  task automatic op(input logic [15:0] w, input logic [31:0] rv, sp,
                    input int gap);
    int n;
    @(posedge clk_sys);
    insn <= '{1'b1, w, 32'h1000, rv, sp};
    n = 0;
    @(negedge clk_sys);
    while (insReady !== 1'b1 && n < 40) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    insn.valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (insReady !== 1'b1 && n < 40);
    gapSeen = n;
    if (gap != 0) begin
      chk(32'(n), 32'(gap));
    end
  endtask
  initial begin
    #(40 * 4000);
    numErrors++;
    completeRun();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    op(16'h0018, 0, 0, 1); chk(tFlag, 1);
    op(16'h0008, 0, 0, 1); chk(tFlag, 0);
    op(16'h8905, 0, 0, 1); chk(loadCnt, 0);
    op(16'h8b05, 0, 0, 3); chk(pcLd.target, 32'h100a);
    chk(pcLd.delayed, 0);
    op(16'h0018, 0, 0, 1);
    op(16'h8b05, 0, 0, 1); chk(loadCnt, 1);
    op(16'h89fe, 0, 0, 3); chk(pcLd.target, 32'h0ffc);
    op(16'hafff, 0, 0, 2); chk(pcLd.target, 32'h0ffe);
    chk(pcLd.delayed, 1);
    op(16'hb002, 0, 0, 2); chk(sysRegs.pr, 32'h1000);
    chk(pcLd.target, 32'h1004);
    op(16'h432b, 32'h2000, 0, 2); chk(pcLd.target, 32'h2000);
    op(16'h432a, 32'h4444, 0, 1); chk(sysRegs.pr, 32'h4444);
    op(16'h000b, 0, 0, 2); chk(pcLd.target, 32'h4444);
    op(16'h430b, 32'h3000, 0, 2); chk(pcLd.target, 32'h3000);
    chk(sysRegs.pr, 32'h1000);
    chk(loadCnt, 7);
    op(16'h410a, 32'h12345678, 0, 1);
    op(16'h411a, 32'h9abc, 0, 1); chk(sysRegs.accumulator_low, 32'h9abc);
    op(16'h050a, 0, 0, 1); chk(wrData, 32'h12345678);
    chk(wrIdx, 5);
    op(16'h0028, 0, 0, 1); chk(sysRegs.accumulator_high | sysRegs.accumulator_low, 0);
    chk(tFlag, 1);
    op(16'h410e, 32'h2, 0, 1); chk(sysRegs.sr, 32'h2);
    chk(tFlag, 0);
    op(16'h411e, 32'h55, 0, 1); chk(sysRegs.global_base_register, 32'h55);
    op(16'h412e, 32'h66, 0, 1); chk(sysRegs.vector_base_register, 32'h66);
    op(16'h0612, 0, 0, 1); chk(wrData, 32'h55);
    op(16'h4217, 32'h100, 0, 3); chk(sysRegs.global_base_register, 32'ha5a50100);
    chk(wrData, 32'h104);
    op(16'h4216, 32'h200, 0, 0);
    repeat (2) @(negedge clk_sys);
    chk(sysRegs.accumulator_low, 32'ha5a50200);
    op(16'h4323, 32'h200, 0, 2); chk(lastAddr, 32'h1fc);
    chk(lastData, 32'h66);
    op(16'h4422, 32'h300, 0, 1);
    repeat (2) @(negedge clk_sys);
    chk(lastAddr, 32'h2fc);
    chk(lastData, 32'h1000);
    @(posedge clk_sys);
    ackDelay <= 2'h2;
    op(16'h4217, 32'h100, 0, 0); chk(gapSeen > 3, 1);
    @(posedge clk_sys);
    ackDelay <= 2'h0;
    op(16'h002b, 0, 32'h500, 4); chk(pcLd.target, 32'ha5a50500);
    chk(sysRegs.sr, 32'ha5a50504);
    chk(wrData, 32'h508);
    op(16'hc304, 0, 32'h400, 8); chk(pcLd.target, 32'ha5a50076);
    chk(lastAddr, 32'h3f8);
    chk(lastData, 32'h1000);
    chk(wrData, 32'h3f8);
    @(posedge clk_sys);
    insn <= '{1'b1, 16'h001b, 32'h1000, 32'h0, 32'h0};
    @(posedge clk_sys);
    insn.valid <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(sleepMode, 0);
    @(negedge clk_sys);
    chk(sleepMode, 1);
    @(posedge clk_sys);
    wakeUp <= 1'b1;
    @(posedge clk_sys);
    wakeUp <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(sleepMode, 0);
    completeRun();
  end
endmodule // tb_branch_sysctl_exec
